/* File: hdl/asc_ctrl.sv */
// Sample timing, power-down and colour mux control for the front end.
// Assumes synchronous pins and a single-cycle register port.
`timescale 1ns/1ns
module asc_ctrl (
   input wire logic clock, // Master clock, 100 MHz
   input wire logic rst_n, // Async reset, active low
   input wire logic [3:0] reg_addr, // Register index
   input wire logic [7:0] reg_wdata, // Write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   output logic [7:0] reg_rdata, // Read data, cycle after strobe
   input wire logic pixel_sync, // Pixel sync pin
   input wire logic autocycle_pulse_pin, // Auto-cycle pulse pin
   output logic sample_strobe, // Take sample this cycle
   output logic [1:0] input_mux_sel, // Selected video input
   output logic [1:0] coef_mux_sel, // Offset and gain register select
   output logic [2:0] channel_power, // Red, green, blue channels on
   output logic adc_power, // Converter on
   output logic parallel_sample, // Three inputs sampled in parallel
   output logic cds_active, // Correlated double sampling on
   output logic [3:0] sync_ratio // Expected clocks per pixel sync
);
   logic [7:0] setup1_r, setup3_r, setup4_r, setup5_r, setup6_r;
   logic [1:0] cyc_r, cyc_nxt;
   logic sync_d_r, acyc_d_r;

   // The sync detector sits behind a carrier so that its tap logic stays
   // separate from the register and mux decode below.
   asc_sync_if sif();


   // Register decode; writes apply even while powered down
   wire wr_s1 = reg_wr & (reg_addr == asc_pkg::ADDR_SETUP1);
   wire wr_s3 = reg_wr & (reg_addr == asc_pkg::ADDR_SETUP3);
   wire wr_s4 = reg_wr & (reg_addr == asc_pkg::ADDR_SETUP4);
   wire wr_s5 = reg_wr & (reg_addr == asc_pkg::ADDR_SETUP5);
   wire wr_s6 = reg_wr & (reg_addr == asc_pkg::ADDR_SETUP6);
   wire wr_acyc_rst = reg_wr & (reg_addr == asc_pkg::ADDR_ACYC_RST);

   // Field views
   wire en = setup1_r[asc_pkg::S1_EN];
   wire cds = setup1_r[asc_pkg::S1_CDS];
   wire mono = setup1_r[asc_pkg::S1_MONO];
   wire selective_powerdown = setup1_r[asc_pkg::S1_SELECTIVE_POWERDOWN];
   wire mode4 = setup1_r[asc_pkg::S1_MODE4];
   wire [1:0] channel_select = setup3_r[asc_pkg::S3_CHAN_LO +: 2];
   wire colour_line_mode = setup4_r[asc_pkg::S4_LINE];
   wire autocycle_select = setup4_r[asc_pkg::S4_ACYC];
   wire force_mux_enable = setup4_r[asc_pkg::S4_FME];
   wire [1:0] internal_colour_select = setup4_r[asc_pkg::S4_INTM_LO +: 2];
   wire [1:0] forced_input_select = setup4_r[asc_pkg::S4_FM_LO +: 2];
   wire sync_edge_detect_en = setup5_r[asc_pkg::S5_DET];
   wire [2:0] sync_delay = setup5_r[asc_pkg::S5_DEL_LO +: 3];
   wire sync_edge_polarity = setup5_r[asc_pkg::S5_POL];
   wire [3:0] block_disable = setup6_r[3:0];

   assign sif.pin = pixel_sync;
   assign sif.det_en = sync_edge_detect_en;
   assign sif.polarity = sync_edge_polarity;
   assign sif.delay = sync_delay;
   asc_sync_detect u_det (
      .clock(clock),
      .rst_n(rst_n),
      .s(sif.det)
   );

   // Pin path: the pin pulse has ended when it reads low after high
   wire pin_end = sync_d_r & ~pixel_sync;
   // The internal pulse is caught this cycle, so the sample falls on the next edge
   wire take_sample = sync_edge_detect_en ? sif.pulse : pin_end;


   // Power-down decode
   // Selective mode ignores the enable bit entirely; a block whose disable
   // bit is clear stays on even with the enable bit low, save green and blue, which colour line mode turns off.
   wire [3:0] blk_on = selective_powerdown ? ~block_disable : {4{en}};
   wire line_mode = colour_line_mode | mono;
   wire [2:0] ch_on_nxt = {blk_on[asc_pkg::BLK_BLUE] & ~colour_line_mode,
                           blk_on[asc_pkg::BLK_GREEN] & ~colour_line_mode,
                           blk_on[asc_pkg::BLK_RED]};


   // Auto-cycle: a rising pin edge advances red, green, blue, red
   // A held-high pin advances only once; the reset write wins over an
   // advance in the same cycle so software always lands on red.
   wire acyc_rise = autocycle_pulse_pin & ~acyc_d_r;
   wire cyc_adv = colour_line_mode & autocycle_select & acyc_rise;
   assign cyc_nxt = wr_acyc_rst ? asc_pkg::COL_RED :
                    ~cyc_adv ? cyc_r :
                    (cyc_r == asc_pkg::COL_BLUE) ? asc_pkg::COL_RED : cyc_r + 2'h1;


   // Mux selection per force and auto-cycle bits
   // Outside line mode the channel select field drives both muxes, so
   // software may rewrite it between lines without touching setup 4.
   wire [1:0] coef_src = autocycle_select ? cyc_r : internal_colour_select;
   wire [1:0] in_line = force_mux_enable ? forced_input_select : coef_src;
   wire [1:0] in_sel_nxt = colour_line_mode ? in_line : channel_select;
   wire [1:0] coef_sel_nxt = colour_line_mode ? coef_src : channel_select;

   // Ratio expected of the controller for the selected mode
   wire [3:0] ratio_nxt = mode4 ? 4'(asc_pkg::RATIO_MAX) :
                          4'(asc_pkg::RATIO_STD);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         setup1_r <= asc_pkg::SETUP1_RST;
         setup3_r <= asc_pkg::SETUP3_RST;
         setup4_r <= asc_pkg::ZERO_RST;
         setup5_r <= asc_pkg::ZERO_RST;
         setup6_r <= asc_pkg::ZERO_RST;
      end else begin
         if (wr_s1) setup1_r <= reg_wdata;
         if (wr_s3) setup3_r <= reg_wdata;
         if (wr_s4) setup4_r <= reg_wdata;
         if (wr_s5) setup5_r <= {3'h0, reg_wdata[4:0]};
         if (wr_s6) setup6_r <= {4'h0, reg_wdata[3:0]};
      end
   end

   // Read mux; unmapped and write-only indices read zero
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      unique case (reg_addr)
         asc_pkg::ADDR_SETUP1: rd_mux = setup1_r;
         asc_pkg::ADDR_SETUP3: rd_mux = setup3_r;
         asc_pkg::ADDR_SETUP4: rd_mux = setup4_r;
         asc_pkg::ADDR_SETUP5: rd_mux = setup5_r;
         asc_pkg::ADDR_SETUP6: rd_mux = setup6_r;
         asc_pkg::ADDR_STATUS: rd_mux = {cyc_r, input_mux_sel, 1'b0, channel_power};
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
         sync_d_r <= 1'b0;
         acyc_d_r <= 1'b0;
         cyc_r <= asc_pkg::COL_RED;
         sample_strobe <= 1'b0;
         input_mux_sel <= asc_pkg::COL_RED;
         coef_mux_sel <= asc_pkg::COL_RED;
         channel_power <= 3'h0;
         adc_power <= 1'b0;
         parallel_sample <= 1'b0;
         cds_active <= 1'b0;
         sync_ratio <= 4'h0;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 8'h00;
         sync_d_r <= pixel_sync;
         acyc_d_r <= autocycle_pulse_pin;
         cyc_r <= cyc_nxt;
         sample_strobe <= take_sample;
         input_mux_sel <= in_sel_nxt;
         coef_mux_sel <= coef_sel_nxt;
         channel_power <= ch_on_nxt;
         adc_power <= blk_on[asc_pkg::BLK_ADC];
         parallel_sample <= ~line_mode;
         cds_active <= cds & ~mode4;
         sync_ratio <= ratio_nxt;
      end
   end

   // Assertions
   a_acyc_reset_red: assert property (@(posedge clock) disable iff (!rst_n)
      wr_acyc_rst |=> (cyc_r == asc_pkg::COL_RED))
      else $error("auto-cycle reset did not select red");
   a_line_powers_down: assert property (@(posedge clock) disable iff (!rst_n)
      colour_line_mode |=> (channel_power[2:1] == 2'h0))
      else $error("green or blue powered in line mode");
   a_pin_sample: assert property (@(posedge clock) disable iff (!rst_n)
      (!sync_edge_detect_en && $fell(pixel_sync)) |=> sample_strobe)
      else $error("no sample after sync fell");
   a_global_enable: assert property (@(posedge clock) disable iff (!rst_n)
      (!selective_powerdown && !en && !colour_line_mode) |=> (channel_power == 3'h0 && !adc_power))
      else $error("global power-down not applied");
   a_selective_off: assert property (@(posedge clock) disable iff (!rst_n)
      (selective_powerdown && block_disable[asc_pkg::BLK_ADC]) |=> !adc_power)
      else $error("disabled converter still on");
   a_cycle_advance: assert property (@(posedge clock) disable iff (!rst_n)
      (cyc_adv && !wr_acyc_rst && cyc_r == asc_pkg::COL_GREEN)
      |=> (cyc_r == asc_pkg::COL_BLUE))
      else $error("auto-cycle did not advance");
   a_force_input: assert property (@(posedge clock) disable iff (!rst_n)
      (colour_line_mode && force_mux_enable) |=> (input_mux_sel == $past(forced_input_select)))
      else $error("forced input not applied");
   a_mono_channel: assert property (@(posedge clock) disable iff (!rst_n)
      (!colour_line_mode) |=> (input_mux_sel == $past(channel_select)))
      else $error("channel select not followed");
   a_max_no_cds: assert property (@(posedge clock) disable iff (!rst_n)
      mode4 |=> !cds_active ##0 (sync_ratio == 4'h2))
      else $error("max speed mode wrong");

   // Sync path checks
   a_rise_detect: assert property (@(posedge clock) disable iff (!rst_n)
      (sync_edge_detect_en && sync_edge_polarity && $rose(pixel_sync)) |-> u_det.edge_hit)
      else $error("rising sync edge missed");

   a_fall_detect: assert property (@(posedge clock) disable iff (!rst_n)
      (sync_edge_detect_en && !sync_edge_polarity && $fell(pixel_sync)) |-> u_det.edge_hit)
      else $error("falling sync edge missed");

   a_detect_off: assert property (@(posedge clock) disable iff (!rst_n)
      !sync_edge_detect_en |-> !u_det.edge_hit)
      else $error("edge pulse while detector off");

   a_delay_seven: assert property (@(posedge clock) disable iff (!rst_n)
      (sync_edge_detect_en && sync_delay == 3'h7 && u_det.edge_hit) |-> ##8 sample_strobe)
      else $error("delayed sync pulse late or lost");

   a_internal_sample: assert property (@(posedge clock) disable iff (!rst_n)
      (sync_edge_detect_en && sif.pulse) |=> sample_strobe)
      else $error("internal pulse not sampled");

   a_pin_replaced: assert property (@(posedge clock) disable iff (!rst_n)
      (sync_edge_detect_en && !sif.pulse) |=> !sample_strobe)
      else $error("pin pulse used with detector on");

   a_pin_idle: assert property (@(posedge clock) disable iff (!rst_n)
      (!sync_edge_detect_en && !pin_end) |=> !sample_strobe)
      else $error("sample without pin pulse end");

   // Power and register checks
   a_enable_up: assert property (@(posedge clock) disable iff (!rst_n)
      (!selective_powerdown && en) |=> (adc_power && channel_power[0]))
      else $error("enabled device not powered");

   a_selective_red: assert property (@(posedge clock) disable iff (!rst_n)
      (selective_powerdown && block_disable[asc_pkg::BLK_RED]) |=> !channel_power[0])
      else $error("disabled red channel still on");

   a_selective_keep: assert property (@(posedge clock) disable iff (!rst_n)
      (selective_powerdown && !block_disable[asc_pkg::BLK_ADC]) |=> adc_power)
      else $error("converter off though not disabled");

   a_line_red_kept: assert property (@(posedge clock) disable iff (!rst_n)
      (colour_line_mode && !selective_powerdown && en) |=> channel_power[0])
      else $error("red channel lost in line mode");

   a_regs_kept: assert property (@(posedge clock) disable iff (!rst_n)
      wr_s6 |=> (setup6_r == {4'h0, $past(reg_wdata[3:0])}))
      else $error("register write lost");

   a_read_setup1: assert property (@(posedge clock) disable iff (!rst_n)
      (reg_rd && reg_addr == asc_pkg::ADDR_SETUP1) |=> (reg_rdata == $past(setup1_r)))
      else $error("setup 1 read back wrong");

   // Mode checks
   a_single_channel: assert property (@(posedge clock) disable iff (!rst_n)
      (colour_line_mode || mono) |=> !parallel_sample)
      else $error("parallel sampling in line mode");

   a_parallel_mode: assert property (@(posedge clock) disable iff (!rst_n)
      (!colour_line_mode && !mono) |=> parallel_sample)
      else $error("pixel mode not parallel");

   a_std_ratio: assert property (@(posedge clock) disable iff (!rst_n)
      !mode4 |=> (sync_ratio == 4'h6))
      else $error("standard ratio wrong");

   a_cds_follow: assert property (@(posedge clock) disable iff (!rst_n)
      (cds && !mode4) |=> cds_active)
      else $error("double sampling not applied");

   // Mux checks
   a_mono_coef: assert property (@(posedge clock) disable iff (!rst_n)
      !colour_line_mode |=> (coef_mux_sel == $past(channel_select)))
      else $error("coefficient select not following channel");

   a_internal_sel: assert property (@(posedge clock) disable iff (!rst_n)
      (colour_line_mode && !force_mux_enable && !autocycle_select)
      |=> (input_mux_sel == $past(internal_colour_select) &&
           coef_mux_sel == $past(internal_colour_select)))
      else $error("internal select not followed");

   a_coef_cycle: assert property (@(posedge clock) disable iff (!rst_n)
      (colour_line_mode && autocycle_select) |=> (coef_mux_sel == $past(cyc_r)))
      else $error("coefficients not cycling");

   a_all_cycle: assert property (@(posedge clock) disable iff (!rst_n)
      (colour_line_mode && autocycle_select && !force_mux_enable)
      |=> (input_mux_sel == $past(cyc_r)))
      else $error("input mux not cycling");

   a_cycle_wrap: assert property (@(posedge clock) disable iff (!rst_n)
      (cyc_adv && !wr_acyc_rst && cyc_r == asc_pkg::COL_BLUE)
      |=> (cyc_r == asc_pkg::COL_RED))
      else $error("auto-cycle did not wrap to red");
endmodule

/* File: hdl/asc_pkg.sv */
// Package for the scanner front-end sample timing and colour mux control.
// Assumes one 100 MHz clock standing in for the master clock; no imports.
package asc_pkg;
   // Register indices on the plain register port
   localparam logic [3:0] ADDR_SETUP1 = 4'h1;
   localparam logic [3:0] ADDR_SETUP3 = 4'h3;
   localparam logic [3:0] ADDR_ACYC_RST = 4'h5;
   localparam logic [3:0] ADDR_SETUP4 = 4'h6;
   localparam logic [3:0] ADDR_SETUP5 = 4'h8;
   localparam logic [3:0] ADDR_SETUP6 = 4'h9;
   localparam logic [3:0] ADDR_STATUS = 4'hA;
   // Reset values
   localparam logic [7:0] SETUP1_RST = 8'h03;
   localparam logic [7:0] SETUP3_RST = 8'h1F;
   localparam logic [7:0] ZERO_RST = 8'h00;
   // Setup 1 fields
   localparam int S1_EN = 0;
   localparam int S1_CDS = 1;
   localparam int S1_MONO = 2;
   localparam int S1_SELECTIVE_POWERDOWN = 3;
   localparam int S1_MODE4 = 6;
   // Setup 3 fields
   localparam int S3_CHAN_LO = 6;
   // Setup 4 fields
   localparam int S4_LINE = 0;
   localparam int S4_ACYC = 1;
   localparam int S4_FME = 2;
   localparam int S4_INTM_LO = 4;
   localparam int S4_FM_LO = 6;
   // Setup 5 fields
   localparam int S5_DET = 0;
   localparam int S5_DEL_LO = 1;
   localparam int S5_POL = 4;
   // Setup 6 block disable: bit per block
   localparam int BLK_RED = 0;
   localparam int BLK_GREEN = 1;
   localparam int BLK_BLUE = 2;
   localparam int BLK_ADC = 3;
   // Colour codes
   localparam logic [1:0] COL_RED = 2'h0;
   localparam logic [1:0] COL_GREEN = 2'h1;
   localparam logic [1:0] COL_BLUE = 2'h2;
   // Clock ratios, master clocks per pixel sync
   localparam int RATIO_STD = 6;
   localparam int RATIO_FAST = 3;
   localparam int RATIO_MAX = 2;
   localparam int RATIO_SLOW_N_MIN = 4;
endpackage

/* File: hdl/asc_sync_detect.sv */
// Pixel sync edge detector with programmable delay.
// Assumes the sync pin is already synchronous to the clock.
`timescale 1ns/1ns
module asc_sync_detect (
   input wire logic clock, // Master clock
   input wire logic rst_n, // Async reset, low
   asc_sync_if.det s // Sync carrier
);
   logic pin_d_r;
   logic [7:0] dly_r;
   wire rise = s.pin & ~pin_d_r;
   wire fall = ~s.pin & pin_d_r;
   wire edge_hit = s.det_en & (s.polarity ? rise : fall);
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pin_d_r <= 1'b0;
         dly_r <= 8'h00;
      end else begin
         pin_d_r <= s.pin;
         dly_r <= {dly_r[6:0], edge_hit};
      end
   end
   // Tap 0 is the undelayed edge pulse; tap n is n clocks later
   assign s.pulse = (s.delay == 3'h0) ? edge_hit : dly_r[s.delay - 3'h1];
endmodule

/* File: hdl/asc_sync_if.sv */
// Carrier between sync detect and the top block.
// Assumes both ends share the one clock.
`timescale 1ns/1ns
interface asc_sync_if;
   logic pin;
   logic det_en;
   logic polarity;
   logic [2:0] delay;
   logic pulse;
   modport det (input pin, input det_en, input polarity, input delay, output pulse);
   modport top (output pin, output det_en, output polarity, output delay, input pulse);
endinterface

/* File: test/asc_sync_model.sv */
// Scanner timing controller model: pixel sync and auto-cycle pulses.
// Assumes it shares the master clock and reset with the control block.
`timescale 1ns/1ns
module asc_sync_model (
   input wire logic clock, // Master clock
   input wire logic rst_n, // Async reset, low
   input wire logic [4:0] period, // Clocks per pixel, 0 stops the sync
   input wire logic square, // 1 half-duty clock, 0 one-clock pulse
   input wire logic fire, // Request one auto-cycle pulse
   output logic pixel_sync, // Pixel sync pin
   output logic autocycle_pulse_pin // Auto-cycle pin
);
   logic [4:0] cnt_r;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 5'h00;
         pixel_sync <= 1'b0;
         autocycle_pulse_pin <= 1'b0;
      end else begin
         autocycle_pulse_pin <= fire;
         if (period == 5'h00) begin
            cnt_r <= 5'h00;
            pixel_sync <= 1'b0;
         end else begin
            // Ratio is the period the bench asks
            cnt_r <= (cnt_r >= period - 5'h01) ? 5'h00 : cnt_r + 5'h01;
            // Square mode stands in for a shift clock; else one-clock pulse
            pixel_sync <= square ? (cnt_r < (period >> 1)) : (cnt_r == 5'h00);
         end
      end
   end
endmodule

/* File: test/tb_asc_ctrl.sv */
// Self-checking bench for the sample timing and colour mux control.
// Assumes the far side model drives both pins from the master clock.
`timescale 1ns/1ns
module tb_asc_ctrl;
   logic clock, rst_n, reg_wr, reg_rd, fire, square, pin_q, dir, mon_on, exp_dir;
   logic pixel_sync, autocycle_pulse_pin, sample_strobe, parallel_sample, cds_active, adc_power;
   logic [3:0] reg_addr, sync_ratio, em;
   logic [7:0] reg_wdata, reg_rdata, rv, s1, s3, s4, s5, s6, age, exp_age;
   logic [1:0] input_mux_sel, coef_mux_sel, cnt;
   logic [2:0] channel_power;
   logic [4:0] period;
   int miscompares, num_checks, nstb;
   logic [3:0] ra [7] = '{4'h1, 4'h3, 4'h6, 4'h8, 4'h9, 4'h5, 4'hF};
   logic [7:0] rvals [7] = '{8'h03, 8'h1F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   asc_ctrl i_dut (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .pixel_sync, .autocycle_pulse_pin, .sample_strobe, .input_mux_sel, .coef_mux_sel,
      .channel_power, .adc_power, .parallel_sample, .cds_active, .sync_ratio);
   asc_sync_model i_far (.clock, .rst_n, .period, .square, .fire, .pixel_sync,
      .autocycle_pulse_pin);
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // Result is {adc, blue, green, red}
   function automatic logic [3:0] exp_pwr(input logic [7:0] a, b, c);
      logic [3:0] p;
      p = a[3] ? ~c[3:0] : {4{a[0]}};
      if (b[0]) p[2:1] = 2'b00;
      return p;
   endfunction
   // Result is {input select, coefficient select}
   function automatic logic [3:0] exp_mux(input logic [7:0] b, input logic [1:0] c, ch);
      logic [1:0] co;
      co = b[1] ? c : b[5:4];
      if (!b[0]) return {ch, ch};
      return {b[2] ? b[7:6] : co, co};
   endfunction
   task automatic chkmux;
      chk("mux", {4'h0, exp_mux(s4, cnt, s3[7:6])}, {4'h0, input_mux_sel, coef_mux_sel});
   endtask
   task automatic pulse;
      @(posedge clock);
      fire <= 1'b1;
      @(posedge clock);
      fire <= 1'b0;
      @(posedge clock);
      #1 chkmux();
      if (s4[1] && s4[0]) cnt = (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
      @(posedge clock);
      #1 chkmux();
   endtask
   // Age counts clocks since the pin was last seen to change
   always @(posedge clock) begin
      if (mon_on && sample_strobe === 1'b1) begin
         nstb++;
         chk("strobe age", exp_age, age);
         chk("strobe edge", {7'h0, exp_dir}, {7'h0, dir});
      end
      age <= (pixel_sync !== pin_q) ? 8'h00 : age + 8'h01;
      if (pixel_sync !== pin_q) dir <= pixel_sync;
      pin_q <= pixel_sync;
   end
   initial begin
      repeat (20000) @(posedge clock);
      miscompares++;
      print_verdict();
   end
   initial begin
      {reg_wr, reg_rd, reg_addr, reg_wdata, fire, square, period, rst_n} = '0;
      {mon_on, pin_q, age, dir, cnt, nstb, miscompares, num_checks} = '0;
      rv = 8'($urandom(57));
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         rd(ra[i], rv);
         chk("reset value", rvals[i], rv);
      end
      $display("test reset done");
      for (int i = 0; i < 14; i++) begin
         s1 = (i == 0) ? 8'h08 : (i == 1) ? 8'h00 : 8'($urandom) & 8'h4F;
         s4 = {7'h00, 1'($urandom)};
         s6 = 8'($urandom) & 8'h0F;
         wr(4'h9, s6);
         wr(4'h6, s4);
         wr(4'h1, s1);
         repeat (2) @(posedge clock);
         #1 chk("power", {4'h0, exp_pwr(s1, s4, s6)}, {4'h0, adc_power, channel_power});
         chk("parallel", {7'h0, ~(s1[2] | s4[0])}, {7'h0, parallel_sample});
         chk("cds", {7'h0, s1[1] & ~s1[6]}, {7'h0, cds_active});
         chk("ratio", 8'(s1[6] ? asc_pkg::RATIO_MAX : asc_pkg::RATIO_STD), {4'h0, sync_ratio});
         rd(4'h1, rv);
         chk("setup1", s1, rv);
         rd(4'h9, rv);
         chk("setup6", s6, rv);
      end
      $display("test power done");
      wr(4'h1, 8'h03);
      wr(4'h9, 8'h00);
      for (int i = 0; i < 6; i++) begin
         s3 = {2'($urandom % 3), 6'h1F};
         s4 = {2'($urandom % 3), 2'($urandom % 3), 1'b0, 1'(i[1]), 1'(i[0]), 1'(i < 4)};
         wr(4'h3, s3);
         wr(4'h6, s4);
         wr(4'h5, 8'($urandom));
         cnt = 2'h0;
         repeat (2) @(posedge clock);
         #1 chkmux();
         repeat (4) pulse();
         em = exp_mux(s4, cnt, s3[7:6]);
         rd(4'hA, rv);
         chk("status", {cnt, em[3:2], 1'b0, s4[0] ? 3'h1 : 3'h7}, rv);
      end
      $display("test mux done");
      wr(4'h6, 8'h00);
      for (int i = 0; i < 6; i++) begin
         s5 = (i == 0) ? 8'h00 : {3'h0, 1'(i[0]), (i == 1) ? 3'h7 : 3'($urandom), 1'b1};
         wr(4'h8, s5);
         exp_age = {5'h00, s5[3:1]};
         exp_dir = s5[0] & s5[4];
         nstb = 0;
         square <= s5[0];
         period <= s5[0] ? 5'h14 : 5'h06;
         mon_on <= 1'b1;
         repeat (120) @(posedge clock);
         period <= 5'h00;
         repeat (12) @(posedge clock);
         mon_on <= 1'b0;
         #1 chk("strobes", 8'h01, {7'h0, nstb >= 4});
      end
      $display("test sync done");
      print_verdict();
   end
endmodule
